// >>> rtl/rmpu_regs.vh
// Register map, field positions and reset values of the range protection checker
`ifndef RMPU_REGS_VH
`define RMPU_REGS_VH

// ----------------------------------------------------------------------------
// Register word addresses
// ----------------------------------------------------------------------------
`define RMPU_OFS_STATUS     10'h000
`define RMPU_OFS_CONFIG     10'h001
`define RMPU_OFS_TRAPS      10'h002
`define RMPU_OFS_DTRAP_ADDR 10'h003
`define RMPU_OFS_FTRAP_ADDR 10'h004
// Table groups sit in address bits 9:4; bits 3:2 set, bits 1:0 entry
`define RMPU_GRP_DLO        6'h10
`define RMPU_GRP_DHI        6'h11
`define RMPU_GRP_DMODE      6'h12
`define RMPU_GRP_CLO        6'h13
`define RMPU_GRP_CHI        6'h14
`define RMPU_GRP_CMODE      6'h15

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define RMPU_CFG_DATA_EN    0
`define RMPU_CFG_CODE_EN    1
`define RMPU_DM_STORE       7
`define RMPU_DM_LOAD        6
`define RMPU_DM_WR_SIG      5
`define RMPU_DM_RD_SIG      4
`define RMPU_DM_LO_WR       3
`define RMPU_DM_LO_RD       2
`define RMPU_DM_UP_WR       1
`define RMPU_DM_UP_RD       0
`define RMPU_CM_FETCH       7
`define RMPU_CM_FETCH_SIG   5
`define RMPU_CM_LO_FETCH    3
`define RMPU_CM_UP_FETCH    0
`define RMPU_CM_DEFINED     8'ha9

// ----------------------------------------------------------------------------
// Encodings and reset values
// ----------------------------------------------------------------------------
`define RMPU_IO_USER0       2'h0
`define RMPU_IO_USER1       2'h1
`define RMPU_IO_SUPER       2'h2
`define RMPU_SEG_PERI_LO    4'he
`define RMPU_SEG_LOCAL_A    4'hc
`define RMPU_SEG_LOCAL_B    4'hd
`define RMPU_SIZE_BYTE      2'h0
`define RMPU_RST_STATUS     2'h0
`define RMPU_RST_CONFIG     2'h0
`define RMPU_RST_WORD       32'h0000_0000
`define RMPU_RST_MODE       8'h00
`define RMPU_RST_TRAPS      6'h00

`endif

// >>> rtl/rmpu_top.v
// Range based memory protection checker for data and fetch accesses
//
// The implementer's own choices: the plain strobed port and the register offsets.
`timescale 1ns/1ps
// Operation
// - A 2-bit active set select in the status word picks the governing set.
// - Entry hits when lower bound <= address < upper bound.
// - Loads/stores check data table; fetch PC checks code table.
// - A hit entry's mode decides permission and debug signals.
// - Number of sets is a parameter from 2 to 4.
// - Cleared permit bits grant nothing; cleared signal bits raise no debug.
// - Entry acts as range comparator, bound equality comparators, or both.
// - Supervisor level never bypasses range checks.
// - With protection enabled, every access is judged before it is performed.
// - I/O level codes: 0 user-0, 1 peripheral user, 2 supervisor.
// - Data modes gate only reads/writes, code modes only fetches.
// - Top nibble e or f is peripheral space, checked apart from tables.
// - Peripheral space refused at level 0, allowed at level 1 or above.
// - Supervisor line on the system bus shows level 2.
// - Protection disabled permits all non-peripheral accesses at any level.
// - Enabled: permit needs a hit whose mode enables the access type.
// - A refused access raises a protection trap instead of proceeding.
// - Permitted access to unimplemented local memory raises a bus error trap.
// - Misaligned access raises an alignment trap, not a protection trap.
// - Only the first byte address is compared against the ranges.
// - Data mode bits 7..0: store, load, wr sig, rd sig, lo wr/rd, up wr/rd.
// - Code mode bits: 7 fetch, 5 fetch sig, 3 lower, 0 upper; rest reserved.
`include "rmpu_regs.vh"

module rmpu_top #(
  parameter        NUM_SETS    = 4,
  parameter [27:0] LOCAL_BYTES = 28'h001_0000
) (
  input  wire        MCLK_I,
  input  wire        SRST_I,
  input  wire [9:0]  REG_ADDR_I,
  input  wire [31:0] REG_WDATA_I,
  input  wire        REG_WR_I,
  input  wire        REG_RD_I,
  output reg  [31:0] REG_RDATA_O,
  input  wire [1:0]  IO_LEVEL_I,
  output reg         SUPERVISOR_O,
  input  wire        D_REQ_I,
  input  wire        D_WRITE_I,
  input  wire [1:0]  D_SIZE_I,
  input  wire [31:0] D_ADDR_I,
  output reg         D_PERMIT_O,
  output reg         D_PROT_TRAP_O,
  output reg         D_ALIGN_TRAP_O,
  output reg         D_BUS_ERR_O,
  output reg  [3:0]  D_RANGE_SIG_O,
  output reg  [3:0]  D_LOWER_SIG_O,
  output reg  [3:0]  D_UPPER_SIG_O,
  input  wire        F_REQ_I,
  input  wire [31:0] F_ADDR_I,
  output reg         F_PERMIT_O,
  output reg         F_PROT_TRAP_O,
  output reg         F_ALIGN_TRAP_O,
  output reg         F_BUS_ERR_O,
  output reg  [3:0]  F_RANGE_SIG_O,
  output reg  [3:0]  F_LOWER_SIG_O,
  output reg  [3:0]  F_UPPER_SIG_O
);

  // --------------------------------------------------------------------------
  // Protection tables and control state
  // --------------------------------------------------------------------------
  reg  [31:0] dlo   [0:15];
  reg  [31:0] dhi   [0:15];
  reg  [7:0]  dmode [0:15];
  reg  [31:0] clo   [0:15];
  reg  [31:0] chi   [0:15];
  reg  [7:0]  cmode [0:15];
  reg  [1:0]  active_set_select;
  reg  [1:0]  prot_enable;
  reg  [5:0]  trap_flags;
  reg  [31:0] dtrap_addr;
  reg  [31:0] ftrap_addr;
  reg  [31:0] next_rdata;
  reg  [5:0]  next_trap_flags;

  wire [5:0]  grp      = REG_ADDR_I[9:4];
  wire [3:0]  tidx     = REG_ADDR_I[3:0];
  // Sets beyond the implemented count are unmapped
  wire        tset_ok  = ({30'h0, REG_ADDR_I[3:2]} < NUM_SETS);
  wire        sel_ok   = ({30'h0, active_set_select} < NUM_SETS);

  integer     di;
  integer     fi;
  integer     ri;
  reg  [3:0]  d_e;
  reg  [7:0]  d_m;
  reg  [3:0]  f_e;
  reg  [7:0]  f_m;
  wire [3:0]  set_base = {active_set_select, 2'h0};
  wire [3:0]  d_in;
  wire [3:0]  d_at_lo;
  wire [3:0]  d_at_hi;
  wire [3:0]  f_in;
  wire [3:0]  f_at_lo;
  wire [3:0]  f_at_hi;
  genvar      g;
  reg         d_hit;
  reg         d_granted;
  reg         f_hit;
  reg         f_granted;
  reg         d_peri;
  reg         f_peri;
  reg         d_misal;
  reg         d_local_gap;
  reg         f_local_gap;
  reg         d_allowed;
  reg         f_allowed;

  // --------------------------------------------------------------------------
  // Bound comparators of the active set
  // --------------------------------------------------------------------------
  generate
    for (g = 0; g < 4; g = g + 1) begin : g_entry
      rmpu_bound_cmp u_dcmp (
        .addr_i     (D_ADDR_I),
        .lower_i    (dlo[set_base + g]),
        .upper_i    (dhi[set_base + g]),
        .valid_i    (sel_ok),
        .in_range_o (d_in[g]),
        .at_lower_o (d_at_lo[g]),
        .at_upper_o (d_at_hi[g])
      );
      rmpu_bound_cmp u_fcmp (
        .addr_i     (F_ADDR_I),
        .lower_i    (clo[set_base + g]),
        .upper_i    (chi[set_base + g]),
        .valid_i    (sel_ok),
        .in_range_o (f_in[g]),
        .at_lower_o (f_at_lo[g]),
        .at_upper_o (f_at_hi[g])
      );
    end
  endgenerate

  // --------------------------------------------------------------------------
  // Data access check
  // --------------------------------------------------------------------------
  // Only the first byte address is compared, so a wide store may run
  // past the range end; leave slack between regions in software.
  always @* begin
    d_hit         = 1'b0;
    d_granted     = 1'b0;
    D_RANGE_SIG_O = 4'h0;
    D_LOWER_SIG_O = 4'h0;
    D_UPPER_SIG_O = 4'h0;
    d_e           = 4'h0;
    d_m           = 8'h00;
    for (di = 0; di < 4; di = di + 1) begin
      d_e = {active_set_select, di[1:0]};
      d_m = dmode[d_e];
      if (d_in[di]) begin
        d_hit = 1'b1;
        if (D_WRITE_I ? d_m[`RMPU_DM_STORE] : d_m[`RMPU_DM_LOAD]) begin
          d_granted = 1'b1;
        end
        D_RANGE_SIG_O[di] = D_REQ_I &
                            (D_WRITE_I ? d_m[`RMPU_DM_WR_SIG] : d_m[`RMPU_DM_RD_SIG]);
      end
      if (d_at_lo[di]) begin
        D_LOWER_SIG_O[di] = D_REQ_I &
                            (D_WRITE_I ? d_m[`RMPU_DM_LO_WR] : d_m[`RMPU_DM_LO_RD]);
      end
      if (d_at_hi[di]) begin
        D_UPPER_SIG_O[di] = D_REQ_I &
                            (D_WRITE_I ? d_m[`RMPU_DM_UP_WR] : d_m[`RMPU_DM_UP_RD]);
      end
    end
  end

  always @* begin
    d_peri      = (D_ADDR_I[31:28] >= `RMPU_SEG_PERI_LO);
    d_misal     = (D_SIZE_I != `RMPU_SIZE_BYTE) && D_ADDR_I[0];
    d_local_gap = ((D_ADDR_I[31:28] == `RMPU_SEG_LOCAL_A) ||
                   (D_ADDR_I[31:28] == `RMPU_SEG_LOCAL_B)) &&
                  (D_ADDR_I[27:0] >= LOCAL_BYTES);
    if (d_peri) begin
      d_allowed = (IO_LEVEL_I != `RMPU_IO_USER0);
    end else if (!prot_enable[`RMPU_CFG_DATA_EN]) begin
      d_allowed = 1'b1;
    end else begin
      // Level plays no part here, supervisor included
      d_allowed = d_hit && d_granted;
    end
    D_ALIGN_TRAP_O = D_REQ_I & d_misal;
    D_PROT_TRAP_O  = D_REQ_I & ~d_misal & ~d_allowed;
    D_BUS_ERR_O    = D_REQ_I & ~d_misal & d_allowed & d_local_gap;
    D_PERMIT_O     = D_REQ_I & ~d_misal & d_allowed & ~d_local_gap;
  end

  // --------------------------------------------------------------------------
  // Fetch check
  // --------------------------------------------------------------------------
  always @* begin
    f_hit         = 1'b0;
    f_granted     = 1'b0;
    F_RANGE_SIG_O = 4'h0;
    F_LOWER_SIG_O = 4'h0;
    F_UPPER_SIG_O = 4'h0;
    f_e           = 4'h0;
    f_m           = 8'h00;
    for (fi = 0; fi < 4; fi = fi + 1) begin
      f_e = {active_set_select, fi[1:0]};
      f_m = cmode[f_e];
      if (f_in[fi]) begin
        f_hit = 1'b1;
        if (f_m[`RMPU_CM_FETCH]) begin
          f_granted = 1'b1;
        end
        F_RANGE_SIG_O[fi] = F_REQ_I & f_m[`RMPU_CM_FETCH_SIG];
      end
      if (f_at_lo[fi]) begin
        F_LOWER_SIG_O[fi] = F_REQ_I & f_m[`RMPU_CM_LO_FETCH];
      end
      if (f_at_hi[fi]) begin
        F_UPPER_SIG_O[fi] = F_REQ_I & f_m[`RMPU_CM_UP_FETCH];
      end
    end
  end

  always @* begin
    f_peri      = (F_ADDR_I[31:28] >= `RMPU_SEG_PERI_LO);
    f_local_gap = ((F_ADDR_I[31:28] == `RMPU_SEG_LOCAL_A) ||
                   (F_ADDR_I[31:28] == `RMPU_SEG_LOCAL_B)) &&
                  (F_ADDR_I[27:0] >= LOCAL_BYTES);
    if (f_peri) begin
      f_allowed = (IO_LEVEL_I != `RMPU_IO_USER0);
    end else if (!prot_enable[`RMPU_CFG_CODE_EN]) begin
      f_allowed = 1'b1;
    end else begin
      f_allowed = f_hit && f_granted;
    end
    F_ALIGN_TRAP_O = F_REQ_I & F_ADDR_I[0];
    F_PROT_TRAP_O  = F_REQ_I & ~F_ADDR_I[0] & ~f_allowed;
    F_BUS_ERR_O    = F_REQ_I & ~F_ADDR_I[0] & f_allowed & f_local_gap;
    F_PERMIT_O     = F_REQ_I & ~F_ADDR_I[0] & f_allowed & ~f_local_gap;
  end

  // --------------------------------------------------------------------------
  // Sticky trap record
  // --------------------------------------------------------------------------
  // A trap in the cycle of a clearing write stays set
  always @* begin
    next_trap_flags = trap_flags;
    if (REG_WR_I && REG_ADDR_I == `RMPU_OFS_TRAPS) begin
      next_trap_flags = trap_flags & ~REG_WDATA_I[5:0];
    end
    next_trap_flags = next_trap_flags |
                      {F_BUS_ERR_O, F_ALIGN_TRAP_O, F_PROT_TRAP_O,
                       D_BUS_ERR_O, D_ALIGN_TRAP_O, D_PROT_TRAP_O};
  end

  // --------------------------------------------------------------------------
  // Register read mux
  // --------------------------------------------------------------------------
  always @* begin
    next_rdata = 32'h0000_0000;
    case (REG_ADDR_I)
      `RMPU_OFS_STATUS:     next_rdata = {30'h0, active_set_select};
      `RMPU_OFS_CONFIG:     next_rdata = {30'h0, prot_enable};
      `RMPU_OFS_TRAPS:      next_rdata = {26'h0, trap_flags};
      `RMPU_OFS_DTRAP_ADDR: next_rdata = dtrap_addr;
      `RMPU_OFS_FTRAP_ADDR: next_rdata = ftrap_addr;
      default: begin
        if (tset_ok) begin
          case (grp)
            `RMPU_GRP_DLO:   next_rdata = dlo[tidx];
            `RMPU_GRP_DHI:   next_rdata = dhi[tidx];
            `RMPU_GRP_DMODE: next_rdata = {24'h0, dmode[tidx]};
            `RMPU_GRP_CLO:   next_rdata = clo[tidx];
            `RMPU_GRP_CHI:   next_rdata = chi[tidx];
            `RMPU_GRP_CMODE: next_rdata = {24'h0, cmode[tidx]};
            default:         next_rdata = 32'h0000_0000;
          endcase
        end
      end
    endcase
  end

  // --------------------------------------------------------------------------
  // Register file and outputs from flops
  // --------------------------------------------------------------------------
  always @(posedge MCLK_I) begin
    if (SRST_I) begin
      for (ri = 0; ri < 16; ri = ri + 1) begin
        dlo[ri]   <= `RMPU_RST_WORD;
        dhi[ri]   <= `RMPU_RST_WORD;
        dmode[ri] <= `RMPU_RST_MODE;
        clo[ri]   <= `RMPU_RST_WORD;
        chi[ri]   <= `RMPU_RST_WORD;
        cmode[ri] <= `RMPU_RST_MODE;
      end
      active_set_select <= `RMPU_RST_STATUS;
      prot_enable       <= `RMPU_RST_CONFIG;
      trap_flags        <= `RMPU_RST_TRAPS;
      dtrap_addr        <= `RMPU_RST_WORD;
      ftrap_addr        <= `RMPU_RST_WORD;
      REG_RDATA_O       <= 32'h0000_0000;
      SUPERVISOR_O      <= 1'b0;
    end else begin
      SUPERVISOR_O <= (IO_LEVEL_I == `RMPU_IO_SUPER);
      REG_RDATA_O  <= REG_RD_I ? next_rdata : 32'h0000_0000;
      trap_flags   <= next_trap_flags;
      if (D_PROT_TRAP_O | D_ALIGN_TRAP_O | D_BUS_ERR_O) begin
        dtrap_addr <= D_ADDR_I;
      end
      if (F_PROT_TRAP_O | F_ALIGN_TRAP_O | F_BUS_ERR_O) begin
        ftrap_addr <= F_ADDR_I;
      end
      if (REG_WR_I) begin
        if (REG_ADDR_I == `RMPU_OFS_STATUS) begin
          active_set_select <= REG_WDATA_I[1:0];
        end
        if (REG_ADDR_I == `RMPU_OFS_CONFIG) begin
          prot_enable <= REG_WDATA_I[1:0];
        end
        if (tset_ok) begin
          case (grp)
            `RMPU_GRP_DLO:   dlo[tidx]   <= REG_WDATA_I;
            `RMPU_GRP_DHI:   dhi[tidx]   <= REG_WDATA_I;
            `RMPU_GRP_DMODE: dmode[tidx] <= REG_WDATA_I[7:0];
            `RMPU_GRP_CLO:   clo[tidx]   <= REG_WDATA_I;
            `RMPU_GRP_CHI:   chi[tidx]   <= REG_WDATA_I;
            // Reserved code mode bits always read as zero
            `RMPU_GRP_CMODE: cmode[tidx] <= REG_WDATA_I[7:0] & `RMPU_CM_DEFINED;
            default:         cmode[tidx] <= cmode[tidx];
          endcase
        end
      end
    end
  end

endmodule

// ----------------------------------------------------------------------------
// One range entry: in-range and bound equality compare
// ----------------------------------------------------------------------------
module rmpu_bound_cmp (
  input  wire [31:0] addr_i,
  input  wire [31:0] lower_i,
  input  wire [31:0] upper_i,
  input  wire        valid_i,
  output wire        in_range_o,
  output wire        at_lower_o,
  output wire        at_upper_o
);

  // Upper bound exclusive, so an entry with equal bounds never hits
  assign in_range_o = valid_i && (addr_i >= lower_i) && (addr_i < upper_i);
  assign at_lower_o = valid_i && (addr_i == lower_i);
  assign at_upper_o = valid_i && (addr_i == upper_i);

endmodule

// >>> verif/rmpu_core_model.sv
// Core load/store and fetch unit model that issues access requests
`timescale 1ns/1ps
module rmpu_core_model (
  input  wire        clk_i,
  input  wire        sup_i,
  output reg  [1:0]  lvl_o,
  output reg         dreq_o,
  output reg         dwr_o,
  output reg  [1:0]  dsz_o,
  output reg  [31:0] dadr_o,
  output reg         freq_o,
  output reg  [31:0] fadr_o,
  output wire        peri_ok_o
);
  // Protected peripheral answers supervisor bus cycles only
  assign peri_ok_o = sup_i;
  initial begin
    lvl_o  = 2'h0;
    dreq_o = 1'b0;
    dwr_o  = 1'b0;
    dsz_o  = 2'h0;
    dadr_o = 32'h0000_0000;
    freq_o = 1'b0;
    fadr_o = 32'h0000_0000;
  end
  task automatic data(input [1:0] lv, input w, input [1:0] sz, input [31:0] a);
    @(posedge clk_i);
    lvl_o  <= lv;
    dreq_o <= 1'b1;
    dwr_o  <= w;
    dsz_o  <= sz;
    dadr_o <= a;
    #1;
  endtask
  task automatic fetch(input [1:0] lv, input [31:0] a);
    @(posedge clk_i);
    lvl_o  <= lv;
    freq_o <= 1'b1;
    fadr_o <= a;
    #1;
  endtask
  // Released address lines do not keep the last value
  task automatic idle;
    @(posedge clk_i);
    dreq_o <= 1'b0;
    freq_o <= 1'b0;
    dadr_o <= ~dadr_o;
    fadr_o <= ~fadr_o;
    #1;
  endtask
endmodule

// >>> verif/rmpu_monitor.sv
// Port checker for the range protection block
`timescale 1ns/1ps
module rmpu_monitor #(
  parameter [27:0] LOCAL_BYTES = 28'h001_0000
) (
  input wire        MCLK_I,
  input wire        SRST_I,
  input wire [1:0]  IO_LEVEL_I,
  input wire        SUPERVISOR_O,
  input wire        D_REQ_I,
  input wire [1:0]  D_SIZE_I,
  input wire [31:0] D_ADDR_I,
  input wire        D_PERMIT_O,
  input wire        D_PROT_TRAP_O,
  input wire        D_ALIGN_TRAP_O,
  input wire        D_BUS_ERR_O,
  input wire [3:0]  D_RANGE_SIG_O,
  input wire        F_REQ_I,
  input wire [31:0] F_ADDR_I,
  input wire        F_PERMIT_O,
  input wire        F_PROT_TRAP_O,
  input wire        F_ALIGN_TRAP_O,
  input wire        F_BUS_ERR_O
);
  default clocking cb @(posedge MCLK_I); endclocking
  default disable iff (SRST_I);
  wire [3:0] d_res  = {D_PERMIT_O, D_PROT_TRAP_O, D_ALIGN_TRAP_O, D_BUS_ERR_O};
  wire [3:0] f_res  = {F_PERMIT_O, F_PROT_TRAP_O, F_ALIGN_TRAP_O, F_BUS_ERR_O};
  wire       d_peri = D_REQ_I && D_SIZE_I == 2'h0 && D_ADDR_I[31:29] == 3'b111;
  a_data_single: assert property (D_REQ_I |-> $onehot(d_res))
    else $error("data outcome not single");
  a_fetch_single: assert property (F_REQ_I |-> $onehot(f_res))
    else $error("fetch outcome not single");
  a_data_idle: assert property (!D_REQ_I |-> d_res == 4'h0 && D_RANGE_SIG_O == 4'h0)
    else $error("data outputs active while idle");
  a_data_misalign: assert property (D_REQ_I && D_SIZE_I != 2'h0 && D_ADDR_I[0]
    |-> D_ALIGN_TRAP_O) else $error("misaligned data not caught");
  a_fetch_misalign: assert property (F_REQ_I && F_ADDR_I[0] |-> F_ALIGN_TRAP_O)
    else $error("misaligned fetch not caught");
  a_peri_user0: assert property (d_peri && IO_LEVEL_I == 2'h0 |-> D_PROT_TRAP_O)
    else $error("peripheral open at level 0");
  a_peri_user1: assert property (d_peri && IO_LEVEL_I != 2'h0 |-> D_PERMIT_O)
    else $error("peripheral refused at level 1 or 2");
  a_super_line: assert property (!$past(SRST_I)
    |-> SUPERVISOR_O == ($past(IO_LEVEL_I) == 2'h2)) else $error("supervisor line wrong");
  a_buserr_local: assert property (D_BUS_ERR_O |-> D_ADDR_I[31:29] == 3'b110
    && D_ADDR_I[27:0] >= LOCAL_BYTES) else $error("bus error outside local gap");
  c_permit: cover property (D_REQ_I && D_PERMIT_O);
  c_fetch_trap: cover property (F_REQ_I && F_PROT_TRAP_O);
  c_bus_err: cover property (D_REQ_I && D_BUS_ERR_O);
endmodule
bind rmpu_top rmpu_monitor #(.LOCAL_BYTES(LOCAL_BYTES)) u_mon (
  .MCLK_I(MCLK_I), .SRST_I(SRST_I), .IO_LEVEL_I(IO_LEVEL_I), .SUPERVISOR_O(SUPERVISOR_O),
  .D_REQ_I(D_REQ_I), .D_SIZE_I(D_SIZE_I), .D_ADDR_I(D_ADDR_I), .D_PERMIT_O(D_PERMIT_O),
  .D_PROT_TRAP_O(D_PROT_TRAP_O), .D_ALIGN_TRAP_O(D_ALIGN_TRAP_O),
  .D_BUS_ERR_O(D_BUS_ERR_O), .D_RANGE_SIG_O(D_RANGE_SIG_O),
  .F_REQ_I(F_REQ_I), .F_ADDR_I(F_ADDR_I), .F_PERMIT_O(F_PERMIT_O),
  .F_PROT_TRAP_O(F_PROT_TRAP_O), .F_ALIGN_TRAP_O(F_ALIGN_TRAP_O),
  .F_BUS_ERR_O(F_BUS_ERR_O));

// >>> verif/tb_range_memory_protection_unit.sv
// Self-checking testbench of the range protection block
`timescale 1ns/1ps
module tb_range_memory_protection_unit;
  reg         MCLK_I, SRST_I, REG_WR_I, REG_RD_I;
  reg  [9:0]  REG_ADDR_I;
  reg  [31:0] REG_WDATA_I;
  wire [31:0] REG_RDATA_O, D_ADDR_I, F_ADDR_I;
  wire [1:0]  IO_LEVEL_I, D_SIZE_I;
  wire        SUPERVISOR_O, D_REQ_I, D_WRITE_I, F_REQ_I, peri_ok;
  wire        D_PERMIT_O, D_PROT_TRAP_O, D_ALIGN_TRAP_O, D_BUS_ERR_O;
  wire        F_PERMIT_O, F_PROT_TRAP_O, F_ALIGN_TRAP_O, F_BUS_ERR_O;
  wire [3:0]  D_RANGE_SIG_O, D_LOWER_SIG_O, D_UPPER_SIG_O;
  wire [3:0]  F_RANGE_SIG_O, F_LOWER_SIG_O, F_UPPER_SIG_O;
  wire [3:0]  d_res = {D_PERMIT_O, D_PROT_TRAP_O, D_ALIGN_TRAP_O, D_BUS_ERR_O};
  wire [3:0]  f_res = {F_PERMIT_O, F_PROT_TRAP_O, F_ALIGN_TRAP_O, F_BUS_ERR_O};
  localparam [3:0] P = 4'h8, T = 4'h4, A = 4'h2, B = 4'h1;
  integer errors = 0;
  integer checks = 0;
  integer cycles = 0;
  // Two sets only, so set select 2 points at nothing
  rmpu_top #(.NUM_SETS(2)) dut (
    .MCLK_I(MCLK_I), .SRST_I(SRST_I), .REG_ADDR_I(REG_ADDR_I),
    .REG_WDATA_I(REG_WDATA_I), .REG_WR_I(REG_WR_I), .REG_RD_I(REG_RD_I),
    .REG_RDATA_O(REG_RDATA_O), .IO_LEVEL_I(IO_LEVEL_I), .SUPERVISOR_O(SUPERVISOR_O),
    .D_REQ_I(D_REQ_I), .D_WRITE_I(D_WRITE_I), .D_SIZE_I(D_SIZE_I), .D_ADDR_I(D_ADDR_I),
    .D_PERMIT_O(D_PERMIT_O), .D_PROT_TRAP_O(D_PROT_TRAP_O),
    .D_ALIGN_TRAP_O(D_ALIGN_TRAP_O), .D_BUS_ERR_O(D_BUS_ERR_O),
    .D_RANGE_SIG_O(D_RANGE_SIG_O), .D_LOWER_SIG_O(D_LOWER_SIG_O),
    .D_UPPER_SIG_O(D_UPPER_SIG_O), .F_REQ_I(F_REQ_I), .F_ADDR_I(F_ADDR_I),
    .F_PERMIT_O(F_PERMIT_O), .F_PROT_TRAP_O(F_PROT_TRAP_O),
    .F_ALIGN_TRAP_O(F_ALIGN_TRAP_O), .F_BUS_ERR_O(F_BUS_ERR_O),
    .F_RANGE_SIG_O(F_RANGE_SIG_O), .F_LOWER_SIG_O(F_LOWER_SIG_O),
    .F_UPPER_SIG_O(F_UPPER_SIG_O));
  rmpu_core_model core (.clk_i(MCLK_I), .sup_i(SUPERVISOR_O), .lvl_o(IO_LEVEL_I),
    .dreq_o(D_REQ_I), .dwr_o(D_WRITE_I), .dsz_o(D_SIZE_I), .dadr_o(D_ADDR_I),
    .freq_o(F_REQ_I), .fadr_o(F_ADDR_I), .peri_ok_o(peri_ok));
  initial begin
    MCLK_I = 1'b0;
    forever #20 MCLK_I = ~MCLK_I;
  end
  // ---------------------------------------------------------------
  // Common tasks
  // ---------------------------------------------------------------
  task automatic chk(input string nm, input [31:0] exp, input [31:0] got);
    checks = checks + 1;
    if (got !== exp) begin
      errors = errors + 1;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic reg_wr(input [9:0] a, input [31:0] d);
    @(posedge MCLK_I);
    REG_ADDR_I  <= a;
    REG_WDATA_I <= d;
    REG_WR_I    <= 1'b1;
    @(posedge MCLK_I);
    REG_WR_I    <= 1'b0;
  endtask
  task automatic reg_rd(input [9:0] a, input [31:0] exp, input string nm);
    @(posedge MCLK_I);
    REG_ADDR_I <= a;
    REG_RD_I   <= 1'b1;
    @(posedge MCLK_I);
    REG_RD_I   <= 1'b0;
    #1 chk(nm, exp, REG_RDATA_O);
  endtask
  task automatic test_done;
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  task automatic s_reset;
    reg_rd(10'h000, 32'h0, "status");
    reg_rd(10'h001, 32'h0, "config");
    reg_rd(10'h124, 32'h0, "data mode");
    reg_rd(10'h3ff, 32'h0, "unmapped");
  endtask
  task automatic s_open;
    core.data(2'h0, 1'b1, 2'h2, 32'h0000_1000); chk("open store", P, d_res);
    core.data(2'h0, 1'b0, 2'h0, 32'he000_0000); chk("peri lvl0", T, d_res);
    core.data(2'h1, 1'b0, 2'h0, 32'hf000_0010); chk("peri lvl1", P, d_res);
    core.data(2'h2, 1'b0, 2'h0, 32'hf000_0010);
    core.idle;
    chk("supervisor", 32'h1, {31'h0, peri_ok});
    core.data(2'h0, 1'b0, 2'h0, 32'hc001_0000); chk("local gap", B, d_res);
    core.data(2'h0, 1'b0, 2'h1, 32'hc000_fffe); chk("local mem", P, d_res);
    reg_rd(10'h002, 32'h5, "trap flags");
    reg_rd(10'h003, 32'hc001_0000, "data trap addr");
    reg_wr(10'h002, 32'h3f);
    reg_rd(10'h002, 32'h0, "flags cleared");
  endtask
  task automatic s_data;
    reg_wr(10'h104, 32'h100);
    reg_wr(10'h114, 32'h200);
    reg_wr(10'h124, 32'h55);
    reg_rd(10'h124, 32'h55, "data mode");
    reg_wr(10'h000, 32'h1);
    reg_wr(10'h001, 32'h1);
    core.data(2'h0, 1'b0, 2'h0, 32'h0ff); chk("below", T, d_res);
    core.data(2'h0, 1'b0, 2'h0, 32'h100); chk("at lower", P, d_res);
    chk("lower sig", 32'h1, D_LOWER_SIG_O);
    chk("range sig", 32'h1, D_RANGE_SIG_O);
    core.data(2'h2, 1'b1, 2'h0, 32'h100); chk("super store", T, d_res);
    chk("store sig", 32'h0, D_RANGE_SIG_O);
    core.data(2'h0, 1'b0, 2'h3, 32'h1fe); chk("straddle", P, d_res);
    core.data(2'h0, 1'b0, 2'h2, 32'h101); chk("misalign", A, d_res);
    core.data(2'h0, 1'b0, 2'h0, 32'h200); chk("at upper", T, d_res);
    chk("upper sig", 32'h1, D_UPPER_SIG_O);
    reg_wr(10'h000, 32'h0);
    core.data(2'h0, 1'b0, 2'h0, 32'h100); chk("set 0", T, d_res);
    reg_wr(10'h128, 32'hff);
    reg_rd(10'h128, 32'h0, "absent set");
    reg_wr(10'h000, 32'h2);
    core.data(2'h0, 1'b0, 2'h0, 32'h100); chk("no set", T, d_res);
    core.idle;
  endtask
  task automatic s_code;
    reg_wr(10'h000, 32'h1);
    reg_wr(10'h001, 32'h3);
    reg_wr(10'h135, 32'h1000);
    reg_wr(10'h145, 32'h1100);
    reg_wr(10'h155, 32'hff);
    reg_rd(10'h155, 32'ha9, "code mode");
    core.fetch(2'h0, 32'h1000); chk("fetch in", P, f_res);
    chk("fetch sig", 32'h2, F_RANGE_SIG_O);
    chk("fetch low", 32'h2, F_LOWER_SIG_O);
    core.fetch(2'h0, 32'h1100); chk("fetch end", T, f_res);
    chk("fetch up", 32'h2, F_UPPER_SIG_O);
    core.fetch(2'h0, 32'h1001); chk("fetch odd", A, f_res);
    core.data(2'h0, 1'b0, 2'h0, 32'h1000); chk("code read", T, d_res);
    core.idle;
    reg_rd(10'h004, 32'h1001, "fetch trap addr");
  endtask
  always @(posedge MCLK_I) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      errors = errors + 1;
      test_done;
    end
  end
  initial begin
    SRST_I      = 1'b1;
    REG_WR_I    = 1'b0;
    REG_RD_I    = 1'b0;
    REG_ADDR_I  = 10'h000;
    REG_WDATA_I = 32'h0;
    repeat (20) @(posedge MCLK_I);
    SRST_I <= 1'b0;
    s_reset;
    s_open;
    s_data;
    s_code;
    test_done;
  end
endmodule
